// ### rdcr_top.sv
`timescale 1ns/1ps
// Purpose: remote control word and frequency reference register bank
// Assumes: link front end delivers decoded single-register reads and writes
// Notes: dig_in pins are synchronised; config inputs come from local logic
module rdcr_top (
  input  wire logic                 clk_in,        // 20 MHz clock
  input  wire logic                 rstn_in,       // async reset, low
  input  wire logic                 ce_in,         // clock enable
  input  wire rdcr_pkg::rdcr_req_s  req_in,        // register request
  output logic [15:0]               rdata_out,     // read data
  output logic                      rvalid_out,    // read data valid pulse
  output logic                      err_out,       // unsupported address pulse
  input  wire logic [2:0]           link_control_permission_in, // permission setting
  input  wire logic [5:0]           dig_in,        // digital input pins
  input  wire logic                 cfg_ref_link_in, // configured ref is link
  input  wire logic                 cfg_ss_link_in,  // configured start is link
  input  wire logic                 cfg_pi_link_in,  // configured PI ref is link
  input  wire logic                 local_run_in,  // configured start/stop run
  input  wire logic signed [15:0]   local_ref_in,  // configured frequency ref
  input  wire logic                 vector_mode_in, // vector control active
  input  wire logic                 fault_in,      // failure latched pulse
  output logic                      fault_out,     // failure message held
  output rdcr_pkg::rdcr_drive_s     drive_out,     // drive command bundle
  output logic [15:0]               freq_mag_out,  // reference magnitude
  output logic                      perm_out       // link control allowed
);
  import rdcr_pkg::*;

  logic [15:0] ctrl_r;
  logic [15:0] freq_r;
  logic [5:0]  dig_s1_r;
  logic [5:0]  dig_s2_r;
  logic        perm;
  logic        ack_done;
  logic        hit_ctrl;
  logic        hit_freq;
  logic        link_ref;
  logic        link_ss;
  logic        blocked;
  logic        run_cmd;
  logic signed [15:0] ref_sel;
  logic signed [15:0] ref_lim;
  logic [15:0] mag;

  function automatic logic signed [15:0] clamp_ref(input logic signed [15:0] v);
    if (v > FREQ_MAX) return FREQ_MAX;
    if (v < FREQ_MIN) return FREQ_MIN;
    return v;
  endfunction

  // only the two mapped addresses decode
  assign hit_ctrl = (req_in.addr == ADDR_CTRL);
  assign hit_freq = (req_in.addr == ADDR_FREQ);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dig_s1_r <= 6'h00;
      dig_s2_r <= 6'h00;
    end else if (ce_in) begin
      dig_s1_r <= dig_in;
      dig_s2_r <= dig_s1_r;
    end
  end

  // permission from setting or digital input
  always_comb begin
    case (link_control_permission_in)
      PERM_NEVER:  perm = 1'b0;
      PERM_ALWAYS: perm = 1'b1;
      default:     perm = dig_s2_r[link_control_permission_in - 3'h1];
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_r <= CTRL_RESET;
    end else if (ce_in && req_in.wr && hit_ctrl) begin
      ctrl_r <= req_in.wdata;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      freq_r <= FREQ_RESET;
    end else if (ce_in && req_in.wr && hit_freq) begin
      freq_r <= req_in.wdata;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out  <= 16'h0000;
      rvalid_out <= 1'b0;
      err_out    <= 1'b0;
    end else if (ce_in) begin
      rvalid_out <= req_in.rd && (hit_ctrl || hit_freq);
      err_out    <= (req_in.rd || req_in.wr) && !(hit_ctrl || hit_freq);
      if (req_in.rd && hit_ctrl) begin
        rdata_out <= ctrl_r;
      end else if (req_in.rd && hit_freq) begin
        rdata_out <= freq_r;
      end
    end
  end

  rdcr_ack_seq u_ack (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .ce_in    (ce_in),
    .valid_in (perm),
    .bit_in   (ctrl_r[BIT_ACK]),
    .done_out (ack_done)
  );

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fault_out <= 1'b0;
    end else if (ce_in) begin
      if (fault_in) begin
        fault_out <= 1'b1;
      end else if (ack_done) begin
        fault_out <= 1'b0;
      end
    end
  end

  // control word bits gated by permission
  assign link_ref = cfg_ref_link_in || (perm && ctrl_r[BIT_FORCE_REF]);
  assign link_ss  = cfg_ss_link_in || (perm && ctrl_r[BIT_FORCE_SS]);
  assign blocked  = perm && (|ctrl_r[BIT_BLK2:BIT_BLK0]);

  always_comb begin
    if (link_ss) begin
      run_cmd = perm && ctrl_r[BIT_RUN];
    end else begin
      run_cmd = local_run_in;
    end
  end

  always_comb begin
    if (link_ref) begin
      ref_sel = perm ? $signed(freq_r) : 16'sh0000;
    end else begin
      ref_sel = local_ref_in;
    end
  end

  assign ref_lim = clamp_ref(ref_sel);
  assign mag = ref_lim[15] ? 16'(-ref_lim) : 16'(ref_lim);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      drive_out    <= '0;
      freq_mag_out <= 16'h0000;
      perm_out     <= 1'b0;
    end else if (ce_in) begin
      drive_out.run          <= run_cmd && !blocked;
      drive_out.block        <= blocked;
      drive_out.use_link_pi  <= perm && (cfg_pi_link_in || ctrl_r[BIT_FORCE_PI]);
      drive_out.use_link_ref <= link_ref;
      drive_out.reverse      <= ref_lim[15];
      drive_out.rpm_units    <= vector_mode_in;
      freq_mag_out           <= mag;
      perm_out               <= perm;
    end
  end

  property p_block_stops;
    @(posedge clk_in) disable iff (!rstn_in)
      (ce_in && blocked) |=> !drive_out.run;
  endproperty
  a_block_stops: assert property (p_block_stops) else $error("run while blocked");

  property p_limit;
    @(posedge clk_in) disable iff (!rstn_in)
      freq_mag_out <= 16'h7d00;
  endproperty
  a_limit: assert property (p_limit) else $error("reference over limit");

  property p_denied_zero;
    @(posedge clk_in) disable iff (!rstn_in)
      (ce_in && !perm && link_ref) |=> (freq_mag_out == 16'h0000);
  endproperty
  a_denied_zero: assert property (p_denied_zero) else $error("denied ref not zero");

  property p_denied_stop;
    @(posedge clk_in) disable iff (!rstn_in)
      (ce_in && !perm && link_ss) |=> !drive_out.run;
  endproperty
  a_denied_stop: assert property (p_denied_stop) else $error("denied link runs");

  property p_readback;
    @(posedge clk_in) disable iff (!rstn_in)
      (ce_in && req_in.rd && hit_ctrl) |=> (rvalid_out && rdata_out == $past(ctrl_r));
  endproperty
  a_readback: assert property (p_readback) else $error("bad readback");

  property p_unmapped;
    @(posedge clk_in) disable iff (!rstn_in)
      (ce_in && req_in.wr && !hit_ctrl && !hit_freq) |=> ($stable(ctrl_r) && $stable(freq_r));
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write changed");

  property p_write;
    @(posedge clk_in) disable iff (!rstn_in)
      (ce_in && req_in.wr && hit_freq) |=> (freq_r == $past(req_in.wdata));
  endproperty
  a_write: assert property (p_write) else $error("write lost");

  property p_ack;
    @(posedge clk_in) disable iff (!rstn_in)
      (ce_in && ack_done && !fault_in) |=> !fault_out;
  endproperty
  a_ack: assert property (p_ack) else $error("fault not erased");

  property p_perm7;
    @(posedge clk_in) disable iff (!rstn_in)
      (ce_in && link_control_permission_in == 3'h7) |=> perm_out;
  endproperty
  a_perm7: assert property (p_perm7) else $error("permission 7 not granted");

  property p_dir;
    @(posedge clk_in) disable iff (!rstn_in)
      ce_in |=> (drive_out.reverse == $past(ref_lim[15]));
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");

  property p_read_freq;
    @(posedge clk_in) disable iff (!rstn_in)
      (ce_in && req_in.rd && hit_freq) |=> (rvalid_out && rdata_out == $past(freq_r));
  endproperty
  a_read_freq: assert property (p_read_freq) else $error("freq readback wrong");

  property p_write_ctrl;
    @(posedge clk_in) disable iff (!rstn_in)
      (ce_in && req_in.wr && hit_ctrl) |=> (ctrl_r == $past(req_in.wdata));
  endproperty
  a_write_ctrl: assert property (p_write_ctrl) else $error("ctrl write lost");

  property p_err;
    @(posedge clk_in) disable iff (!rstn_in)
      (ce_in && (req_in.rd || req_in.wr) && !hit_ctrl && !hit_freq) |=> (err_out && !rvalid_out);
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");

  property p_fault_set;
    @(posedge clk_in) disable iff (!rstn_in)
      (ce_in && fault_in) |=> fault_out;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not latched");

  property p_run_local;
    @(posedge clk_in) disable iff (!rstn_in)
      (ce_in && !link_ss && !blocked) |=> (drive_out.run == $past(local_run_in));
  endproperty
  a_run_local: assert property (p_run_local) else $error("local run not followed");

  property p_run_link;
    @(posedge clk_in) disable iff (!rstn_in)
      (ce_in && link_ss && perm && !blocked) |=> (drive_out.run == $past(ctrl_r[BIT_RUN]));
  endproperty
  a_run_link: assert property (p_run_link) else $error("link run not followed");

  property p_pi_denied;
    @(posedge clk_in) disable iff (!rstn_in)
      (ce_in && !perm) |=> !drive_out.use_link_pi;
  endproperty
  a_pi_denied: assert property (p_pi_denied) else $error("pi forced without permission");

  property p_force_pi;
    @(posedge clk_in) disable iff (!rstn_in)
      (ce_in && perm && ctrl_r[BIT_FORCE_PI]) |=> drive_out.use_link_pi;
  endproperty
  a_force_pi: assert property (p_force_pi) else $error("pi forcing ignored");

  property p_force_ref;
    @(posedge clk_in) disable iff (!rstn_in)
      (ce_in && perm && ctrl_r[BIT_FORCE_REF]) |=> drive_out.use_link_ref;
  endproperty
  a_force_ref: assert property (p_force_ref) else $error("ref forcing ignored");

  property p_perm0;
    @(posedge clk_in) disable iff (!rstn_in)
      (ce_in && link_control_permission_in == PERM_NEVER) |=> !perm_out;
  endproperty
  a_perm0: assert property (p_perm0) else $error("permission 0 not denied");

  property p_rpm;
    @(posedge clk_in) disable iff (!rstn_in)
      ce_in |=> (drive_out.rpm_units == $past(vector_mode_in));
  endproperty
  a_rpm: assert property (p_rpm) else $error("units flag wrong");
endmodule

// ### rdcr_pkg.sv
// Purpose: constants and types for the remote drive control register bank
// Assumes: single 20 MHz clock, register port driven by a link front end
// Notes: register indices are the decimal link addresses
package rdcr_pkg;
  localparam int unsigned DATA_W        = 16;
  localparam logic [15:0] ADDR_CTRL     = 16'h07d0;
  localparam logic [15:0] ADDR_FREQ     = 16'h07d1;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] FREQ_RESET    = 16'h0000;
  localparam int unsigned BIT_ACK       = 1;
  localparam int unsigned BIT_FORCE_PI  = 4;
  localparam int unsigned BIT_FORCE_REF = 5;
  localparam int unsigned BIT_FORCE_SS  = 6;
  localparam int unsigned BIT_BLK0      = 12;
  localparam int unsigned BIT_BLK2      = 14;
  localparam int unsigned BIT_RUN       = 15;
  localparam logic [2:0]  PERM_NEVER    = 3'h0;
  localparam logic [2:0]  PERM_ALWAYS   = 3'h7;
  localparam logic signed [15:0] FREQ_MAX = 16'sh7d00;
  localparam logic signed [15:0] FREQ_MIN = -16'sh7d00;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } rdcr_req_s;

  typedef struct packed {
    logic        run;
    logic        block;
    logic        use_link_pi;
    logic        use_link_ref;
    logic        reverse;
    logic        rpm_units;
  } rdcr_drive_s;
endpackage

// ### rdcr_ack_seq.sv
`timescale 1ns/1ps
// Purpose: detect the fault acknowledge pattern low, high, low
// Assumes: bit_in sampled on every enabled clock
// Notes: one-cycle pulse on completion
module rdcr_ack_seq (
  input  wire logic clk_in,   // clock
  input  wire logic rstn_in,  // async reset, low
  input  wire logic ce_in,    // clock enable
  input  wire logic valid_in, // permission granted
  input  wire logic bit_in,   // control word bit 1
  output logic      done_out  // pulse on full sequence
);
  typedef enum logic [1:0] {ACK_IDLE, ACK_LOW, ACK_HIGH} rdcr_ack_e;
  rdcr_ack_e st_r;
  rdcr_ack_e st_nxt;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ACK_IDLE: if (!bit_in) st_nxt = ACK_LOW;
      ACK_LOW:  if (bit_in) st_nxt = ACK_HIGH;
      ACK_HIGH: if (!bit_in) st_nxt = ACK_LOW;
      default:  st_nxt = ACK_IDLE;
    endcase
    if (!valid_in) st_nxt = ACK_IDLE;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= ACK_IDLE;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= valid_in && (st_r == ACK_HIGH) && !bit_in;
    end
  end
endmodule

// ### rdcr_link_master.sv
`timescale 1ns/1ps
// Purpose: link master model issuing single-register requests
// Assumes: requests launched 1 ns after a rising edge
// Notes: released address and data lines carry the inverse of the last value
module rdcr_link_master (
  input  wire logic           clk_in,  // register clock
  output rdcr_pkg::rdcr_req_s req_out  // request to the bank
);
  import rdcr_pkg::*;
  initial req_out = '0;
  task automatic xfer(input int gap, input logic w, input logic [15:0] a,
                      input logic [15:0] d);
    repeat (gap) @(posedge clk_in);
    @(posedge clk_in);
    #1 req_out = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_in);
    #1 req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

// ### rdcr_top_tb.sv
`timescale 1ns/1ps
// Purpose: self-checking bench for the remote drive control registers
// Assumes: one link master model, read answers checked in order
// Notes: level outputs checked after a settling wait of a few cycles
module rdcr_top_tb;
  import rdcr_pkg::*;
  logic              clk_in, rstn_in, ce_in, cfg_ref, cfg_ss, cfg_pi;
  logic              lrun, vec, fin, rvalid, err, fout, perm;
  logic [2:0]        psel;
  logic [5:0]        dig;
  logic signed [15:0] lref;
  logic [15:0]       rdata, mag;
  logic [31:0]       r;
  rdcr_req_s         req;
  rdcr_drive_s       drv;
  logic [16:0]       q[$];
  logic [15:0]       fv[4] = '{16'h09c4, 16'hfb3c, 16'h7fff, 16'h8000};
  logic [15:0]       fm[4] = '{16'h09c4, 16'h04c4, 16'h7d00, 16'h7d00};
  int                n_fail, checks_done;

  rdcr_link_master m (.clk_in(clk_in), .req_out(req));
  rdcr_top uut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .req_in(req),
    .rdata_out(rdata), .rvalid_out(rvalid), .err_out(err),
    .link_control_permission_in(psel), .dig_in(dig), .cfg_ref_link_in(cfg_ref),
    .cfg_ss_link_in(cfg_ss), .cfg_pi_link_in(cfg_pi), .local_run_in(lrun),
    .local_ref_in(lref), .vector_mode_in(vec), .fault_in(fin), .fault_out(fout),
    .drive_out(drv), .freq_mag_out(mag), .perm_out(perm));

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // unmapped addresses expect an error pulse instead of data
  task wr(input logic [15:0] a, input logic [15:0] d);
    if (a != ADDR_CTRL && a != ADDR_FREQ) q.push_back(17'h10000);
    m.xfer(int'($urandom % 3), 1'b1, a, d);
  endtask
  task rd(input logic [15:0] a, input logic [15:0] e);
    q.push_back((a == ADDR_CTRL || a == ADDR_FREQ) ? {1'b0, e} : 17'h10000);
    m.xfer(int'($urandom % 3), 1'b0, a, 16'h0000);
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  always @(posedge clk_in) begin : mon
    logic [16:0] e;
    if (rvalid === 1'b1 || err === 1'b1) begin
      e = (q.size() > 0) ? q.pop_front() : 17'h1ffff;
      chk(16'(err), 16'(e[16]));
      if (!e[16]) chk(rdata, e[15:0]);
    end
  end

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    #2000000;
    n_fail++;
    end_sim;
  end

  initial begin
    rstn_in = 1'b0; ce_in = 1'b1; psel = PERM_ALWAYS; dig = 6'h00;
    cfg_ref = 1'b0; cfg_ss = 1'b0; cfg_pi = 1'b0; lrun = 1'b0;
    lref = 16'sh0064; vec = 1'b0; fin = 1'b0; n_fail = 0; checks_done = 0;
    r = $urandom(19);
    repeat (5) @(posedge clk_in);
    #1 rstn_in = 1'b1;
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_FREQ, FREQ_RESET);
    wr(16'h07d2, 16'hffff);
    wr(16'h07cf, 16'hffff);
    rd(16'h07d2, 16'h0000);
    rd(ADDR_CTRL, CTRL_RESET);
    repeat (4) begin
      r = $urandom;
      wr(ADDR_CTRL, r[15:0]);
      rd(ADDR_CTRL, r[15:0]);
    end
    lrun = 1'b1;
    wr(ADDR_CTRL, 16'h0000);
    wt(4);
    chk(16'(drv.run), 16'h0001);
    wr(ADDR_CTRL, 16'h8040);
    wt(4);
    chk(16'(drv.run), 16'h0001);
    wr(ADDR_CTRL, 16'h0040);
    wt(4);
    chk(16'(drv.run), 16'h0000);
    for (int b = 12; b <= 14; b++) begin
      wr(ADDR_CTRL, (b == 12 ? 16'h8040 : 16'h0000) | (16'h0001 << b));
      wt(4);
      chk(16'(drv.run), 16'h0000);
      chk(16'(drv.block), 16'h0001);
    end
    // failure stays until the full low-high-low pattern
    fin = 1'b1;
    @(posedge clk_in);
    #1 fin = 1'b0;
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_CTRL, 16'h0002);
    wt(4);
    chk(16'(fout), 16'h0001);
    wr(ADDR_CTRL, 16'h0000);
    wt(4);
    chk(16'(fout), 16'h0000);
    wr(ADDR_CTRL, 16'h0020);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_FREQ, fv[i]);
      rd(ADDR_FREQ, fv[i]);
      wt(3);
      chk(mag, fm[i]);
      chk(16'(drv.reverse), 16'(fv[i][15]));
      chk(16'(drv.use_link_ref), 16'h0001);
    end
    wr(ADDR_CTRL, 16'h0010);
    vec = 1'b1;
    wt(4);
    chk(mag, 16'h0064);
    chk(16'(drv.use_link_pi), 16'h0001);
    chk(16'(drv.rpm_units), 16'h0001);
    psel = PERM_NEVER;
    cfg_ref = 1'b1;
    cfg_ss = 1'b1;
    wr(ADDR_CTRL, 16'h8070);
    wt(4);
    chk(16'(perm), 16'h0000);
    chk(16'(drv.run), 16'h0000);
    chk(16'(drv.use_link_pi), 16'h0000);
    chk(mag, 16'h0000);
    rd(ADDR_CTRL, 16'h8070);
    for (int n = 1; n <= 6; n++) begin
      psel = 3'(n);
      dig = 6'h01 << (n - 1);
      wt(5);
      chk(16'(perm), 16'h0001);
      dig = ~(6'h01 << (n - 1));
      wt(5);
      chk(16'(perm), 16'h0000);
    end
    psel = PERM_ALWAYS;
    wt(4);
    chk(16'(drv.run), 16'h0001);
    chk(mag, 16'h7d00);
    // frozen clock enable: this write must not land
    ce_in = 1'b0;
    m.xfer(0, 1'b1, ADDR_CTRL, 16'h0000);
    wt(2);
    ce_in = 1'b1;
    rd(ADDR_CTRL, 16'h8070);
    wt(2);
    // mid-run reset brings both words back to zero
    rstn_in = 1'b0;
    wt(2);
    rstn_in = 1'b1;
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_FREQ, FREQ_RESET);
    wt(4);
    chk(16'(drv.run), 16'h0000);
    chk(mag, 16'h0000);
    wt(4);
    chk(16'(q.size()), 16'h0000);
    end_sim;
  end
endmodule
